// >>> flash_prot_cfg.svh
`ifndef FLASH_PROT_CFG_SVH
`define FLASH_PROT_CFG_SVH

`define FP_FLASH_BYTES 8192
`define FP_UNIT_BYTES 1024
`define FP_REGION_UNITS 2
`define FP_WORD_BYTES 4
`define FP_WORD_BITS 32
`define FP_ERASED_WORD 32'hFFFF_FFFF
`define FP_ZERO_WORD 32'h0000_0000

`endif

// >>> flash_prot_pkg.sv
package flash_prot_pkg;

  typedef enum logic [2:0] {
    CMD_FETCH,
    CMD_DATA_READ,
    CMD_DEBUG_READ,
    CMD_PROGRAM,
    CMD_ERASE
  } cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_PROG,
    ST_ERASE
  } state_t;

endpackage : flash_prot_pkg

// >>> flash_array.sv
`timescale 1ns/1ps
// =============================================================
// Flash storage array
// =============================================================
// Read-first single port; read data appears one cycle after the address.
module flash_array #(
  parameter int WORDS = 2048,
  parameter int DW = 32,
  parameter int AW = $clog2(WORDS)
) (
  input wire logic clk_sys_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic we_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [WORDS];

  always_ff @(posedge clk_sys_i) begin
    rdata_o <= mem[addr_i];
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

endmodule : flash_array

// >>> flash_block_protection.sv
`timescale 1ns/1ps
`include "flash_prot_cfg.svh"
module flash_block_protection import flash_prot_pkg::*; #(
  parameter int FLASH_BYTES = `FP_FLASH_BYTES,
  parameter int UNIT_BYTES = `FP_UNIT_BYTES,
  parameter int REGION_UNITS = `FP_REGION_UNITS,
  parameter int DW = `FP_WORD_BITS,
  parameter int REGIONS = FLASH_BYTES / (UNIT_BYTES * REGION_UNITS),
  parameter int BA = $clog2(FLASH_BYTES)
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic req_valid_i,
  input wire cmd_t req_cmd_i,
  input wire logic [BA-1:0] req_addr_i,
  input wire logic [DW-1:0] req_wdata_i,
  input wire logic [REGIONS-1:0] prot_ro_i,
  input wire logic [REGIONS-1:0] prot_xo_i,
  input wire logic viol_clr_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic rsp_denied_o,
  output logic [DW-1:0] rsp_rdata_o,
  output logic viol_o
);

  localparam int WORDS = FLASH_BYTES / `FP_WORD_BYTES;
  localparam int AW = $clog2(WORDS);
  localparam int UW = $clog2(UNIT_BYTES / `FP_WORD_BYTES);
  localparam int RGW = $clog2(REGIONS);
  localparam int WB = $clog2(`FP_WORD_BYTES);

  // =============================================================
  // Request decode
  // =============================================================
  function automatic logic [RGW-1:0] region_of(input logic [AW-1:0] w);
    region_of = w[AW-1 -: RGW];
  endfunction : region_of

  function automatic logic is_denied(input cmd_t c, input logic ro, input logic xo);
    is_denied = 1'b0;
    if ((c == CMD_PROGRAM || c == CMD_ERASE) && (ro || xo)) begin
      is_denied = 1'b1;
    end else if ((c == CMD_DATA_READ || c == CMD_DEBUG_READ) && xo) begin
      is_denied = 1'b1;
    end
  endfunction : is_denied

  state_t state_q;
  state_t state_d;
  logic ready_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] wdata_q;
  logic rsp_valid_q;
  logic rsp_denied_q;
  logic [DW-1:0] rsp_rdata_q;
  logic viol_q;
  logic [AW-1:0] req_word;
  logic [RGW-1:0] req_region;
  logic acc;
  logic denied;
  logic erase_last;
  logic [AW-1:0] mem_addr;
  logic mem_we;
  logic [DW-1:0] mem_wdata;
  logic [DW-1:0] mem_rdata;

  assign req_word = req_addr_i[BA-1:WB];
  assign req_region = region_of(req_word);
  assign acc = req_valid_i && ready_q;
  assign denied = is_denied(req_cmd_i, prot_ro_i[req_region], prot_xo_i[req_region]);
  assign erase_last = (addr_q[UW-1:0] == {UW{1'b1}});

  // =============================================================
  // Sequencer
  // =============================================================
  always_comb begin
    state_d = state_q;
    mem_addr = addr_q;
    mem_we = 1'b0;
    mem_wdata = `FP_ERASED_WORD;
    case (state_q)
      ST_IDLE: begin
        mem_addr = req_word;
        if (acc && !denied) begin
          case (req_cmd_i)
            CMD_PROGRAM: state_d = ST_PROG;
            CMD_ERASE: state_d = ST_ERASE;
            default: state_d = ST_READ;
          endcase
        end
      end
      ST_READ: begin
        state_d = ST_IDLE;
      end
      ST_PROG: begin
        // Programming can only clear bits, as in a real flash cell.
        mem_we = 1'b1;
        mem_wdata = mem_rdata & wdata_q;
        state_d = ST_IDLE;
      end
      ST_ERASE: begin
        mem_we = 1'b1;
        mem_wdata = `FP_ERASED_WORD;
        if (erase_last) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ready_q <= (state_d == ST_IDLE);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      addr_q <= '0;
      wdata_q <= `FP_ZERO_WORD;
    end else if (state_q == ST_IDLE && acc) begin
      wdata_q <= req_wdata_i;
      if (req_cmd_i == CMD_ERASE) begin
        addr_q <= {req_word[AW-1:UW], {UW{1'b0}}};
      end else begin
        addr_q <= req_word;
      end
    end else if (state_q == ST_ERASE) begin
      addr_q <= {addr_q[AW-1:UW], addr_q[UW-1:0] + {{(UW-1){1'b0}}, 1'b1}};
    end
  end

  // =============================================================
  // Responses and violation flag
  // =============================================================
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rsp_valid_q <= 1'b0;
      rsp_denied_q <= 1'b0;
      rsp_rdata_q <= `FP_ZERO_WORD;
    end else begin
      rsp_valid_q <= 1'b0;
      rsp_denied_q <= 1'b0;
      if (state_q == ST_IDLE && acc && denied) begin
        rsp_valid_q <= 1'b1;
        rsp_denied_q <= 1'b1;
        rsp_rdata_q <= `FP_ZERO_WORD;
      end else if (state_q == ST_READ) begin
        rsp_valid_q <= 1'b1;
        rsp_rdata_q <= mem_rdata;
      end else if (state_q == ST_PROG || (state_q == ST_ERASE && erase_last)) begin
        rsp_valid_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      viol_q <= 1'b0;
    end else if (acc && denied) begin
      viol_q <= 1'b1;
    end else if (viol_clr_i) begin
      viol_q <= 1'b0;
    end
  end

  assign req_ready_o = ready_q;
  assign rsp_valid_o = rsp_valid_q;
  assign rsp_denied_o = rsp_denied_q;
  assign rsp_rdata_o = rsp_rdata_q;
  assign viol_o = viol_q;

  flash_array #(
    .WORDS(WORDS),
    .DW(DW),
    .AW(AW)
  ) u_array (
    .clk_sys_i(clk_sys_i),
    .addr_i(mem_addr),
    .we_i(mem_we),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  // =============================================================
  // Checks
  // =============================================================
  chk_denied_resp: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    acc && denied |=> rsp_valid_o && rsp_denied_o && viol_o)
    else $error("denied access gave no denied response");

  chk_denied_nowrite: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    acc && denied |=> !mem_we && state_q == ST_IDLE)
    else $error("denied access reached the array");

  chk_ro_refuse: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    acc && (req_cmd_i == CMD_PROGRAM || req_cmd_i == CMD_ERASE) && prot_ro_i[req_region]
    |=> rsp_denied_o)
    else $error("read-only region accepted a write");

  chk_xo_refuse: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    acc && (req_cmd_i == CMD_PROGRAM || req_cmd_i == CMD_ERASE) && prot_xo_i[req_region]
    |=> rsp_denied_o)
    else $error("execute-only region accepted a write");

  chk_xo_noread: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    acc && (req_cmd_i == CMD_DATA_READ || req_cmd_i == CMD_DEBUG_READ) && prot_xo_i[req_region]
    |=> rsp_denied_o && rsp_rdata_o == `FP_ZERO_WORD)
    else $error("execute-only region leaked a data read");

  chk_fetch_allowed: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    acc && req_cmd_i == CMD_FETCH |=> !rsp_valid_o ##1 rsp_valid_o && !rsp_denied_o)
    else $error("instruction fetch not answered in two cycles");

  chk_erase_ones: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state_q == ST_ERASE |-> mem_we && mem_wdata == `FP_ERASED_WORD)
    else $error("erase wrote a word other than all ones");

  chk_erase_unit: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state_q == ST_ERASE && $past(state_q) == ST_ERASE
    |-> addr_q[AW-1:UW] == $past(addr_q[AW-1:UW]))
    else $error("erase walked out of its unit");

  chk_erase_len: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    acc && !denied && req_cmd_i == CMD_ERASE |-> ##257 (rsp_valid_o && ready_q))
    else $error("erase did not finish after one unit of words");

  chk_viol_sticky: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    viol_o && !viol_clr_i |=> viol_o)
    else $error("violation flag dropped without a clear");

endmodule : flash_block_protection

// >>> bus_requester.sv
`timescale 1ns/1ps
// ==========================================================
// Requester standing in for the fetch, data and debug buses
// ==========================================================
module bus_requester import flash_prot_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic req_ready_i,
  output logic req_valid_o,
  output cmd_t req_cmd_o,
  output logic [12:0] req_addr_o,
  output logic [31:0] req_wdata_o
);
  initial begin
    req_valid_o = 1'b0;
    req_cmd_o = CMD_FETCH;
    req_addr_o = 13'h0000;
    req_wdata_o = 32'h0000_0000;
  end

  // Holds the request until an edge samples ready high, then inverts the address and data lines.
  task automatic issue(input cmd_t c, input logic [12:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    req_valid_o <= 1'b1;
    req_cmd_o <= c;
    req_addr_o <= a;
    req_wdata_o <= d;
    do @(posedge clk_sys_i); while (req_ready_i !== 1'b1);
    req_valid_o <= 1'b0;
    req_addr_o <= ~a;
    req_wdata_o <= ~d;
  endtask : issue
endmodule : bus_requester

// >>> test_flash_block_protection.sv
`timescale 1ns/1ps
// ==========================================================
// Testbench
// ==========================================================
module test_flash_block_protection;
  import flash_prot_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_valid_i, req_ready_o, rsp_valid_o, rsp_denied_o, viol_o;
  logic viol_clr_i = 1'b0;
  cmd_t req_cmd_i;
  logic [12:0] req_addr_i;
  logic [31:0] req_wdata_i, rsp_rdata_o;
  logic [3:0] prot_ro_i = 4'h0;
  logic [3:0] prot_xo_i = 4'h0;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  flash_block_protection uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .prot_ro_i(prot_ro_i), .prot_xo_i(prot_xo_i),
    .viol_clr_i(viol_clr_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_denied_o(rsp_denied_o), .rsp_rdata_o(rsp_rdata_o), .viol_o(viol_o));

  bus_requester bus (.clk_sys_i(clk_sys_i), .req_ready_i(req_ready_o),
    .req_valid_o(req_valid_i), .req_cmd_o(req_cmd_i), .req_addr_o(req_addr_i),
    .req_wdata_o(req_wdata_i));

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      results();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : chk

  // One request, then its answer, its latency and its data are judged.
  task automatic op(input cmd_t c, input logic [12:0] a, input logic [31:0] d,
                    input logic den, input logic [31:0] rd);
    int n;
    int lat;
    bus.issue(c, a, d);
    lat = den ? 1 : ((c == CMD_ERASE) ? 257 : 2);
    // The answer of a denied request already stands after the taking edge.
    for (n = 1; n < 300; n++) begin
      #1;
      if (rsp_valid_o === 1'b1) break;
      @(posedge clk_sys_i);
    end
    chk("latency", n, lat);
    chk("denied", rsp_denied_o, den);
    if (c < CMD_PROGRAM || den) chk("rdata", rsp_rdata_o, rd);
    if (den) chk("viol", viol_o, 1);
  endtask : op

  task automatic t_erase();
    op(CMD_ERASE, 13'h0400, 0, 0, 0);
    op(CMD_PROGRAM, 13'h0404, 32'h1234_5678, 0, 0);
    op(CMD_ERASE, 13'h0000, 0, 0, 0);
    op(CMD_DATA_READ, 13'h03FC, 0, 0, 32'hFFFF_FFFF);
    op(CMD_DATA_READ, 13'h0404, 0, 0, 32'h1234_5678);
    op(CMD_ERASE, 13'h1C00, 0, 0, 0);
    op(CMD_PROGRAM, 13'h1FFC, 32'hA5A5_0000, 0, 0);
    op(CMD_FETCH, 13'h1FFE, 0, 0, 32'hA5A5_0000);
  endtask : t_erase

  task automatic t_ro();
    for (int r = 0; r < 4; r++) begin
      @(posedge clk_sys_i);
      prot_ro_i <= 4'h1 << r;
      op(CMD_ERASE, 13'(r * 2048 + 1024), 0, 1, 0);
      op(CMD_PROGRAM, 13'(r * 2048 + 4), 0, 1, 0);
      op(CMD_ERASE, 13'(((r + 1) % 4) * 2048), 0, 0, 0);
    end
    @(posedge clk_sys_i);
    prot_ro_i <= 4'h1;
    op(CMD_DATA_READ, 13'h0404, 0, 0, 32'h1234_5678);
  endtask : t_ro

  task automatic t_xo();
    @(posedge clk_sys_i);
    prot_ro_i <= 4'h0;
    prot_xo_i <= 4'h1;
    op(CMD_PROGRAM, 13'h0404, 0, 1, 0);
    op(CMD_ERASE, 13'h0400, 0, 1, 0);
    op(CMD_DATA_READ, 13'h0404, 0, 1, 0);
    op(CMD_DEBUG_READ, 13'h0404, 0, 1, 0);
    op(CMD_FETCH, 13'h0404, 0, 0, 32'h1234_5678);
    op(CMD_DATA_READ, 13'h0804, 0, 0, 32'hFFFF_FFFF);
  endtask : t_xo

  // The clear stands while a denied read is taken, so the set must win there.
  task automatic t_clear();
    @(posedge clk_sys_i);
    viol_clr_i <= 1'b1;
    op(CMD_DATA_READ, 13'h0404, 0, 1, 0);
    @(posedge clk_sys_i);
    viol_clr_i <= 1'b0;
    #1;
    chk("viol", viol_o, 0);
  endtask : t_clear

  initial begin
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("ready", req_ready_o, 1);
    chk("viol", viol_o, 0);
    t_erase();
    t_ro();
    t_xo();
    t_clear();
    results();
  end
endmodule : test_flash_block_protection
